// ### dv/pch_config_header_test.sv
// Self-checking bench for the configuration header
`timescale 1ns/100ps
`include "pch_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module pch_config_header_test;
   logic                ref_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                card_mode = 1'b0;
   logic [5:0]          hits = 6'h00;
   wire logic           cfg_req, cfg_we, cfg_ack, pci_mode;
   wire logic [7:0]     cfg_addr;
   pch_pkg::pch_be_t    cfg_be;
   pch_pkg::pch_dword_t cfg_wdata, cfg_rdata, rd;
   wire logic [8:0]     gate;
   int                  failures = 0;
   int                  tests_run = 0;
   pch_pkg::pch_half_t  cmd_tab[4] = '{16'h0000, 16'h0052, 16'h0104, 16'h0156};

   always #20 ref_clk = ~ref_clk;

   pch_host_model i_host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
      .cfg_rdata(cfg_rdata));

   pch_config_header i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .card_mode(card_mode),
      .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .pci_mode(pci_mode),
      .mem_hit(hits[5]), .io_hit(hits[4]), .mst_req(hits[3]), .mst_line_wr(hits[2]),
      .parity_err(hits[1]), .sys_err(hits[0]), .mem_claim(gate[8]), .io_claim(gate[7]),
      .mst_go(gate[6]), .mst_use_mwi(gate[5]), .perr_out(gate[4]), .serr_out(gate[3]),
      .spc_monitor(gate[2]), .step_en(gate[1]), .palette_snoop(gate[0]));

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cfg(input logic we, input logic [7:0] addr, input pch_pkg::pch_be_t be,
                      input pch_pkg::pch_dword_t wdata, input logic exp_ack);
      logic acked;
      i_host.access(we, addr, be, wdata, rd, acked);
      `CHK(acked, exp_ack)
      if (exp_ack && acked !== 1'b1)
         stop_test();
   endtask

   task automatic rd_chk(input logic [7:0] addr, input pch_pkg::pch_dword_t exp);
      cfg(1'b0, addr, 4'hf, 32'h0, 1'b1);
      `CHK(rd, exp)
   endtask

   task automatic wait_mode();
      int n;
      for (n = 0; n < 10 && pci_mode !== 1'b1; n++)
         @(posedge ref_clk);
      if (pci_mode !== 1'b1) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic gate_chk(input pch_pkg::pch_half_t c);
      cfg(1'b1, `PCH_OFS_CMD, 4'h3, {16'hffff, c}, 1'b1);
      hits <= 6'h3f;
      repeat (2) @(posedge ref_clk);
      `CHK(gate[8:5], {c[1], 1'b0, c[2], c[2] & c[4]})
      `CHK(gate[4:0], {c[6], c[8], 3'b000})
      hits <= 6'h00;
      repeat (2) @(posedge ref_clk);
      `CHK(gate, 9'h000)
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_mode();
      rd_chk(`PCH_OFS_MAKER, {`PCH_PART_CODE, `PCH_MAKER_CODE});
      rd_chk(`PCH_OFS_CMD, 32'h00000006);
      cfg(1'b1, `PCH_OFS_MAKER, 4'hf, 32'hffffffff, 1'b1);
      rd_chk(`PCH_OFS_MAKER, {`PCH_PART_CODE, `PCH_MAKER_CODE});
      cfg(1'b1, `PCH_OFS_CMD, 4'h1, 32'hffffffff, 1'b1);
      rd_chk(`PCH_OFS_CMD, 32'h00000056);
      cfg(1'b1, `PCH_OFS_CMD, 4'h2, 32'hffffffff, 1'b1);
      rd_chk(`PCH_OFS_CMD, 32'h00000156);
      rd_chk(8'h10, 32'h00000000);
      foreach (cmd_tab[i])
         gate_chk(cmd_tab[i]);
      card_mode <= 1'b1;
      hits <= 6'h3f;
      repeat (4) @(posedge ref_clk);
      `CHK({pci_mode, gate}, 10'h000)
      cfg(1'b1, `PCH_OFS_CMD, 4'h3, 32'h0, 1'b0);
      card_mode <= 1'b0;
      hits <= 6'h00;
      wait_mode();
      rd_chk(`PCH_OFS_CMD, 32'h00000156);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_mode();
      rd_chk(`PCH_OFS_CMD, 32'h00000006);
      stop_test();
   end
endmodule

// ### dv/pch_host_model.sv
// Host bridge model issuing type-0 configuration cycles
`timescale 1ns/100ps
module pch_host_model (
   input  wire logic                ref_clk,    // Clock
   output logic                     cfg_req,    // Request pulse
   output logic                     cfg_we,     // Write when high
   output logic [7:0]               cfg_addr,   // Byte address
   output pch_pkg::pch_be_t         cfg_be,     // Byte enables
   output pch_pkg::pch_dword_t      cfg_wdata,  // Write data
   input  wire logic                cfg_ack,    // Completion
   input  wire pch_pkg::pch_dword_t cfg_rdata   // Read data
);
   initial begin
      cfg_req = 1'b0;
      cfg_we = 1'b0;
      cfg_addr = 8'hff;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
   end

   task automatic access(input logic we, input logic [7:0] addr, input pch_pkg::pch_be_t be,
                         input pch_pkg::pch_dword_t wdata, output pch_pkg::pch_dword_t rdata,
                         output logic acked);
      int n;
      acked = 1'b0;
      rdata = 32'h0;
      @(posedge ref_clk);
      cfg_req <= 1'b1;
      cfg_we <= we;
      cfg_addr <= addr;
      cfg_be <= be;
      cfg_wdata <= wdata;
      @(posedge ref_clk);
      cfg_req <= 1'b0;
      // Released lines carry the inverse so stale values never match
      cfg_we <= ~we;
      cfg_addr <= ~addr;
      cfg_be <= ~be;
      cfg_wdata <= ~wdata;
      for (n = 0; n < 3 && acked !== 1'b1; n++) begin
         @(posedge ref_clk);
         if (cfg_ack === 1'b1) begin
            acked = 1'b1;
            rdata = cfg_rdata;
         end
      end
   endtask
endmodule

// ### rtl/pch_cmd_reg.sv
// Command register storage with byte-lane writes
`timescale 1ns/100ps
`include "pch_map.svh"
module pch_cmd_reg (
   input  wire logic              ref_clk,  // Clock
   input  wire logic              rst_n,    // Sync reset, active low
   input  wire logic              wr_lo,    // Write strobe, byte lane 0
   input  wire logic              wr_hi,    // Write strobe, byte lane 1
   input  wire pch_pkg::pch_half_t wdata,   // Write data
   output pch_pkg::pch_half_t     cmd       // Current command value
);
   localparam pch_pkg::pch_half_t WR_MASK = `PCH_CMD_WR_MASK; // RULE14 RULE15
   localparam pch_pkg::pch_half_t RST_VAL = `PCH_CMD_RST;

   pch_pkg::pch_half_t cmd_r;
   pch_pkg::pch_half_t cmd_nxt;
   wire pch_pkg::pch_half_t lane_mask;

   // Only writable bits in enabled lanes change
   assign lane_mask = {{8{wr_hi}}, {8{wr_lo}}} & WR_MASK;    // RULE16
   assign cmd_nxt   = (cmd_r & ~lane_mask) | (wdata & lane_mask); // RULE16
   assign cmd       = cmd_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cmd_r <= RST_VAL;                                   // RULE5 RULE7
      end else begin
         cmd_r <= cmd_nxt;
      end
   end
endmodule

// ### rtl/pch_config_header.sv
// PCI bus mode configuration header: identification and command gating
//
// Contract
// (RULE1) The header answers only while the card-mode select input is low.
// (RULE2) Offset 0 returns a fixed read-only maker code that writes cannot change.
// (RULE3) Offset 2 returns a fixed read-only part code.
// (RULE4) Command bit 0 reads 0 and I/O-space cycles are never claimed.
// (RULE5) Command bit 1 is writable, resets to 1, and gates claiming decoded memory cycles.
// (RULE6) Configuration software should set the memory enable bit during power-up.
// (RULE7) Command bit 2 is writable, resets to 1, and while 0 blocks all mastering.
// (RULE8) Command bit 3 reads 0 and special cycles are never monitored.
// (RULE9) Command bit 4 is writable, resets to 0, and only while 1 allows invalidate writes.
// (RULE10) Command bit 5 reads 0 and palette snooping never happens.
// (RULE11) Command bit 6 is writable, resets to 0, and gates parity error signalling.
// (RULE12) Command bit 7 reads 0 and stepping is never used.
// (RULE13) Command bit 8 is writable, resets to 0, and gates system error signalling.
// (RULE14) Command bit 9 reads 0; fast back-to-back only to the same agent.
// (RULE15) Command bits 15 to 10 read as zero and ignore writes.
// (RULE16) Writes to read-only bits complete but change nothing; lanes gate writable bits.
// (RULE17) Type-0 configuration cycles complete whatever the memory enable says.
`timescale 1ns/100ps
`include "pch_map.svh"
module pch_config_header #(
   parameter logic [15:0] MAKER_CODE = `PCH_MAKER_CODE, // Arbitrary value
   parameter logic [15:0] PART_CODE  = `PCH_PART_CODE   // Arbitrary value
) (
   input  wire logic               ref_clk,       // PCI clock
   input  wire logic               rst_n,         // PCI reset, sync, active low
   input  wire logic               card_mode,     // Card-mode select pin, low = PCI
   input  wire logic               cfg_req,       // Type-0 config cycle, one pulse
   input  wire logic               cfg_we,        // Config write when high
   input  wire logic [7:0]         cfg_addr,      // Dword byte address
   input  wire pch_pkg::pch_be_t   cfg_be,        // Byte enables, high active
   input  wire pch_pkg::pch_dword_t cfg_wdata,    // Config write data
   output logic                    cfg_ack,       // Config cycle completed
   output pch_pkg::pch_dword_t     cfg_rdata,     // Config read data
   output logic                    pci_mode,      // PCI mode selected
   input  wire logic               mem_hit,       // Memory address decoded
   input  wire logic               io_hit,        // I/O address decoded
   input  wire logic               mst_req,       // Master wants the bus
   input  wire logic               mst_line_wr,   // Master write is a full line
   input  wire logic               parity_err,    // Parity error detected
   input  wire logic               sys_err,       // System error detected
   output logic                    mem_claim,     // Claim memory cycle
   output logic                    io_claim,      // Claim I/O cycle
   output logic                    mst_go,        // Master may start
   output logic                    mst_use_mwi,   // Use invalidate write command
   output logic                    perr_out,      // Signal parity error
   output logic                    serr_out,      // Signal system error
   output logic                    spc_monitor,   // Special cycle monitor
   output logic                    step_en,       // Address/data stepping
   output logic                    palette_snoop  // Palette snooping
);
   localparam logic [7:0] OFS_MAKER = `PCH_OFS_MAKER;
   localparam logic [7:0] OFS_CMD   = `PCH_OFS_CMD;

   logic               mode_s1_r;
   logic               pci_sel_r;
   logic               cfg_ack_r;
   pch_pkg::pch_dword_t cfg_rdata_r;
   logic               mem_claim_r;
   logic               mst_go_r;
   logic               mwi_r;
   logic               perr_r;
   logic               serr_r;
   logic               io_claim_r;
   logic               fixed_off_r;
   pch_pkg::pch_half_t cmd;

   wire logic               pci_sel;
   wire logic               take;
   wire logic               hit_id;
   wire logic               hit_cmd;
   wire logic               cmd_wr_lo;
   wire logic               cmd_wr_hi;
   wire pch_pkg::pch_dword_t id_word;
   wire pch_pkg::pch_dword_t cmd_word;
   wire pch_pkg::pch_dword_t rd_word;

   // Card-mode pin synchroniser
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_s1_r <= 1'b1;
         pci_sel_r <= 1'b0;
      end else begin
         mode_s1_r <= card_mode;
         pci_sel_r <= ~mode_s1_r;                                // RULE1
      end
   end

   assign pci_sel = pci_sel_r;                                   // RULE1
   assign take    = cfg_req & pci_sel;                           // RULE1 RULE17
   assign hit_id  = (cfg_addr[7:2] == OFS_MAKER[7:2]);
   assign hit_cmd = (cfg_addr[7:2] == OFS_CMD[7:2]);
   assign cmd_wr_lo = take & cfg_we & hit_cmd & cfg_be[0];       // RULE16
   assign cmd_wr_hi = take & cfg_we & hit_cmd & cfg_be[1];       // RULE16

   // Identification is constant; writes to it fall through
   assign id_word  = {PART_CODE, MAKER_CODE};                    // RULE2 RULE3
   // Upper half holds status, outside this block, read as zero
   assign cmd_word = {16'h0000, cmd};                            // RULE15
   assign rd_word  = hit_id  ? id_word  :
                     hit_cmd ? cmd_word : 32'h0000_0000;

   pch_cmd_reg u_cmd (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_lo   (cmd_wr_lo),
      .wr_hi   (cmd_wr_hi),
      .wdata   (cfg_wdata[15:0]),
      .cmd     (cmd)
   );

   // Config completion, independent of memory enable
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_ack_r   <= 1'b0;
         cfg_rdata_r <= 32'h0000_0000;
      end else begin
         cfg_ack_r   <= take;                                    // RULE17
         cfg_rdata_r <= (take & ~cfg_we) ? rd_word : 32'h0000_0000;
      end
   end

   // Gating of bus behaviour by command bits
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mem_claim_r <= 1'b0;
         mst_go_r    <= 1'b0;
         mwi_r       <= 1'b0;
         perr_r      <= 1'b0;
         serr_r      <= 1'b0;
         io_claim_r  <= 1'b0;
         fixed_off_r <= 1'b0;
      end else begin
         mem_claim_r <= pci_sel & mem_hit & cmd[`PCH_CMD_MEM];   // RULE5
         mst_go_r    <= pci_sel & mst_req & cmd[`PCH_CMD_MST];   // RULE7
         mwi_r       <= pci_sel & mst_req & cmd[`PCH_CMD_MST]
                        & mst_line_wr & cmd[`PCH_CMD_MWI];       // RULE9
         perr_r      <= pci_sel & parity_err & cmd[`PCH_CMD_PERR]; // RULE11
         serr_r      <= pci_sel & sys_err & cmd[`PCH_CMD_SERR];  // RULE13
         io_claim_r  <= 1'b0;                                    // RULE4
         fixed_off_r <= 1'b0;                                    // RULE8 RULE10 RULE12
      end
   end

   assign cfg_ack       = cfg_ack_r;
   assign cfg_rdata     = cfg_rdata_r;
   assign pci_mode      = pci_sel_r;
   assign mem_claim     = mem_claim_r;
   assign io_claim      = io_claim_r;
   assign mst_go        = mst_go_r;
   assign mst_use_mwi   = mwi_r;
   assign perr_out      = perr_r;
   assign serr_out      = serr_r;
   assign spc_monitor   = fixed_off_r;
   assign step_en       = fixed_off_r;
   assign palette_snoop = fixed_off_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_mode_gate;
      cfg_ack |-> $past(cfg_req) && $past(pci_sel_r);
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("ack outside PCI mode"); // RULE1

   property p_maker;
      take && !cfg_we && hit_id |=> cfg_rdata[15:0] == MAKER_CODE;
   endproperty
   a_maker: assert property (p_maker) else $error("maker code wrong"); // RULE2

   property p_part;
      take && !cfg_we && hit_id |=> cfg_rdata[31:16] == PART_CODE;
   endproperty
   a_part: assert property (p_part) else $error("part code wrong"); // RULE3

   property p_io_never;
      !io_claim && !cmd[`PCH_CMD_IO];
   endproperty
   a_io_never: assert property (p_io_never) else $error("I/O space active"); // RULE4

   property p_mem_claim;
      mem_claim |-> $past(mem_hit) && $past(cmd[`PCH_CMD_MEM]);
   endproperty
   a_mem_claim: assert property (p_mem_claim) else $error("memory claim not enabled"); // RULE5

   property p_mem_follow;
      pci_sel && mem_hit && cmd[`PCH_CMD_MEM] |=> mem_claim;
   endproperty
   a_mem_follow: assert property (p_mem_follow) else $error("decoded cycle not claimed"); // RULE5

   property p_master;
      mst_go || mst_use_mwi |-> $past(cmd[`PCH_CMD_MST]);
   endproperty
   a_master: assert property (p_master) else $error("master without enable"); // RULE7

   property p_mwi;
      mst_use_mwi |-> $past(cmd[`PCH_CMD_MWI]) && mst_go;
   endproperty
   a_mwi: assert property (p_mwi) else $error("invalidate write not enabled"); // RULE9

   property p_fixed;
      !spc_monitor && !palette_snoop && !step_en
      && cmd[15:9] == 7'h00 && !cmd[`PCH_CMD_SPC] && !cmd[`PCH_CMD_VGA]
      && !cmd[`PCH_CMD_STEP];
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed bit set"); // RULE8 RULE10 RULE12 RULE14

   property p_perr;
      perr_out |-> $past(parity_err) && $past(cmd[`PCH_CMD_PERR]);
   endproperty
   a_perr: assert property (p_perr) else $error("parity signal not enabled"); // RULE11

   property p_serr;
      serr_out |-> $past(sys_err) && $past(cmd[`PCH_CMD_SERR]);
   endproperty
   a_serr: assert property (p_serr) else $error("system error not enabled"); // RULE13

   property p_lane_keep;
      take && cfg_we && hit_cmd && !cfg_be[0] |=> $stable(cmd[7:0]);
   endproperty
   a_lane_keep: assert property (p_lane_keep) else $error("disabled lane written"); // RULE16

   property p_complete;
      take |=> cfg_ack ##1 !cfg_ack || $past(take);
   endproperty
   a_complete: assert property (p_complete) else $error("config cycle not completed"); // RULE17
endmodule

// ### rtl/pch_map.svh
// Offsets, field positions and reset values of the configuration header
`ifndef PCH_MAP_SVH
`define PCH_MAP_SVH

// Byte offsets in configuration space
`define PCH_OFS_MAKER     8'h00
`define PCH_OFS_PART      8'h02
`define PCH_OFS_CMD       8'h04

// Command register field positions
`define PCH_CMD_IO        0
`define PCH_CMD_MEM       1
`define PCH_CMD_MST       2
`define PCH_CMD_SPC       3
`define PCH_CMD_MWI       4
`define PCH_CMD_VGA       5
`define PCH_CMD_PERR      6
`define PCH_CMD_STEP      7
`define PCH_CMD_SERR      8
`define PCH_CMD_FB2B      9

// Command register reset value and writable bits
`define PCH_CMD_RST       16'h0006
`define PCH_CMD_WR_MASK   16'h0156

// Arbitrary neutral identity codes
`define PCH_MAKER_CODE    16'h5a5a
`define PCH_PART_CODE     16'h0101

`endif

// ### rtl/pch_pkg.sv
// Types shared by the configuration header modules
package pch_pkg;
   typedef logic [15:0] pch_half_t;
   typedef logic [31:0] pch_dword_t;
   typedef logic [3:0]  pch_be_t;
endpackage
